// >>> hw/cmp_i2c_dev.sv
`timescale 1ns/1ps
module cmp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Full and empty from the occupancy count
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;

    // Storage; pointers wrap naturally, so depth must be a power of two
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : cmp_fifo

// Function
// - Link runs at standard 100 kbps rate
// - Eight bits then one acknowledge bit
// - Payload bytes in, binary bytes out
// - Negative values sent in two's complement
// - Answers address bytes 42 write, 43 read
// - Device only pulls low or releases lines
// - Master starts transfers and makes clock
// - Master gives ninth clock, releases data
// - Receiver pulls data low to acknowledge
// - Data changes only while clock low
// - Start and stop are edges during high clock
// - Repeated start opens a new address phase
// - Address byte: seven address bits, direction
// - Direction one reads, zero writes
// - Master ends each transaction with stop
// - Write holds command plus two arguments
module cmp_i2c_dev (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    cmp_i2c_if.dev                     bus,
    output logic                       rx_valid,
    input  wire logic                  rx_ready,
    output logic [cmp_pkg::BYTE_W-1:0] rx_data,
    output logic                       rx_first,
    input  wire logic [cmp_pkg::BYTE_W-1:0] tx_data,
    output logic                       tx_taken,
    output logic                       selected
);
    import cmp_pkg::*;

    cmp_dev_state_t      state;
    logic [2:0]          scl_sync;
    logic [2:0]          sda_sync;
    logic                scl_q;
    logic                sda_q;
    logic                scl_agree;
    logic                sda_agree;
    logic                scl_rise;
    logic                scl_fall;
    logic                bus_start;
    logic                bus_stop;
    logic [2:0]          bit_cnt;
    logic                got_byte;
    logic [BYTE_W-1:0]   shreg;
    logic [1:0]          wr_count;
    logic                master_ack;
    logic                push_valid;
    logic [FIFO_WIDTH-1:0] push_data;
    logic                fifo_ready;

    // Three-stage sync; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            scl_sync <= SYNC_IDLE;
            sda_sync <= SYNC_IDLE;
        end else if (clk_en) begin
            scl_sync <= {scl_sync[1:0], bus.scl};
            sda_sync <= {sda_sync[1:0], bus.sda};
        end
    end

    // Filtered levels move only when stages two and three agree
    assign scl_agree = (scl_sync[1] == scl_sync[2]);
    assign sda_agree = (sda_sync[1] == sda_sync[2]);
    assign scl_rise  = scl_agree && scl_sync[2] && !scl_q;
    assign scl_fall  = scl_agree && !scl_sync[2] && scl_q;
    assign bus_start = sda_agree && !sda_sync[2] && sda_q && scl_q;
    assign bus_stop  = sda_agree && sda_sync[2] && !sda_q && scl_q;

    // Filtered line levels
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            if (scl_agree) begin
                scl_q <= scl_sync[2];
            end
            if (sda_agree) begin
                sda_q <= sda_sync[2];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus.sda_dev_o <= 1'b0;
        end
    end

    // bytes stored as received
    // Count has already stepped when the push lands, so the first byte sees one
    assign push_data = {(wr_count == 2'h1), shreg};

    // Protocol engine; bus conditions beat clock edges
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state          <= CMP_D_IDLE;
            bit_cnt        <= '0;
            got_byte       <= 1'b0;
            shreg          <= '0;
            wr_count       <= '0;
            master_ack     <= 1'b0;
            push_valid     <= 1'b0;
            tx_taken       <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (clk_en) begin
            push_valid <= 1'b0;
            tx_taken   <= 1'b0;
            if (bus_start) begin
                state          <= CMP_D_ADDR;
                bit_cnt        <= '0;
                got_byte       <= 1'b0;
                bus.sda_dev_oe <= 1'b0;
            end else if (bus_stop) begin
                state          <= CMP_D_IDLE;
                bus.sda_dev_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    CMP_D_ADDR, CMP_D_WRX: begin
                        shreg   <= {shreg[BYTE_W-2:0], sda_q};
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == 3'h7) begin
                            got_byte <= 1'b1;
                        end
                    end
                    CMP_D_TXB: begin
                        bit_cnt <= bit_cnt + 1'b1;
                    end
                    CMP_D_RACK: begin
                        master_ack <= (sda_q == ACK_LEVEL);
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    CMP_D_ADDR: begin
                        if (got_byte) begin
                            got_byte <= 1'b0;
                            if (shreg[BYTE_W-1:1] == SLAVE_ADDR) begin
                                bus.sda_dev_oe <= 1'b1;
                                state          <= CMP_D_AACK;
                            end else begin
                                state <= CMP_D_SKIP;
                            end
                        end
                    end
                    CMP_D_AACK: begin
                        wr_count <= '0;
                        bit_cnt  <= '0;
                        if (shreg[0] == DIR_READ) begin
                            shreg          <= tx_data;
                            tx_taken       <= 1'b1;
                            bus.sda_dev_oe <= !tx_data[BYTE_W-1];
                            state          <= CMP_D_TXB;
                        end else begin
                            bus.sda_dev_oe <= 1'b0;
                            state          <= CMP_D_WRX;
                        end
                    end
                    CMP_D_WRX: begin
                        if (got_byte) begin
                            got_byte <= 1'b0;
                            state    <= CMP_D_WACK;
                            if (wr_count != 2'(MAX_WR_BYTES) && fifo_ready) begin
                                bus.sda_dev_oe <= 1'b1;
                                push_valid     <= 1'b1;
                                wr_count       <= wr_count + 1'b1;
                            end
                        end
                    end
                    CMP_D_WACK: begin
                        bus.sda_dev_oe <= 1'b0;
                        state          <= CMP_D_WRX;
                    end
                    CMP_D_TXB: begin
                        if (bit_cnt == 3'h0) begin
                            // Release for the master's acknowledge
                            bus.sda_dev_oe <= 1'b0;
                            state          <= CMP_D_RACK;
                        end else begin
                            shreg          <= {shreg[BYTE_W-2:0], 1'b0};
                            bus.sda_dev_oe <= !shreg[BYTE_W-2];
                        end
                    end
                    CMP_D_RACK: begin
                        if (master_ack) begin
                            shreg          <= tx_data;
                            tx_taken       <= 1'b1;
                            bus.sda_dev_oe <= !tx_data[BYTE_W-1];
                            state          <= CMP_D_TXB;
                        end else begin
                            state <= CMP_D_SKIP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Selected flag: addressed and not yet ended
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            selected <= 1'b0;
        end else if (clk_en) begin
            selected <= (state != CMP_D_IDLE) && (state != CMP_D_ADDR)
                        && (state != CMP_D_SKIP);
        end
    end

    // Full buffer refuses bytes by negative acknowledge
    cmp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (push_valid),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  ({rx_first, rx_data})
    );
endmodule : cmp_i2c_dev

// >>> hw/cmp_pkg.sv
package cmp_pkg;
    // Link timing, in the units the figures are given in
    localparam int CLK_PERIOD_NS = 25;
    localparam int BIT_RATE_BPS  = 100_000;
    localparam int BIT_PERIOD_NS = 1_000_000_000 / BIT_RATE_BPS;
    // Quarter bit in clock cycles; rounded down keeps the rate at or over the limit
    localparam int QTR_CYC       = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int QCNT_W        = 7;

    // Transfer shape: eight data bits plus one acknowledge bit
    localparam int BYTE_W        = 8;
    localparam int XFER_BITS     = 9;
    localparam int MAX_WR_BYTES  = 3;
    localparam int MAX_RD_BYTES  = 2;

    // Address bytes at factory default; bit 0 is the direction flag
    localparam logic [7:0] ADDR_WR_BYTE = 8'h42;
    localparam logic [7:0] ADDR_RD_BYTE = 8'h43;
    localparam logic [6:0] SLAVE_ADDR   = ADDR_WR_BYTE[7:1];
    localparam logic       DIR_READ     = 1'b1;
    localparam logic       ACK_LEVEL    = 1'b0;

    // Receive buffer shape
    localparam int FIFO_WIDTH    = 9;
    localparam int FIFO_DEPTH    = 32;

    // Synchroniser reset value: idle lines sit high
    localparam logic [2:0] SYNC_IDLE = 3'h7;

    typedef enum logic [2:0] {
        CMP_D_IDLE,
        CMP_D_ADDR,
        CMP_D_AACK,
        CMP_D_WRX,
        CMP_D_WACK,
        CMP_D_TXB,
        CMP_D_RACK,
        CMP_D_SKIP
    } cmp_dev_state_t;

    typedef enum logic [1:0] {
        CMP_H_IDLE,
        CMP_H_START,
        CMP_H_BIT,
        CMP_H_STOP
    } cmp_host_state_t;
endpackage : cmp_pkg

// >>> hw/cmp_i2c_if.sv
`timescale 1ns/1ps
interface cmp_i2c_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Pull-ups: a line is high unless an enabled driver pulls it low
    assign scl = !(scl_host_oe && !scl_host_o);
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

    modport host (
        output scl_host_o,
        output scl_host_oe,
        output sda_host_o,
        output sda_host_oe,
        input  scl,
        input  sda
    );

    modport dev (
        output sda_dev_o,
        output sda_dev_oe,
        input  scl,
        input  sda
    );
endinterface : cmp_i2c_if

// >>> hw/cmp_i2c_host.sv
`timescale 1ns/1ps
module cmp_i2c_host (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    cmp_i2c_if.host          bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [1:0]  cmd_len,
    input  wire logic [23:0] cmd_wdata,
    output logic             done,
    output logic             nack,
    output logic [15:0]      rd_data
);
    import cmp_pkg::*;

    cmp_host_state_t   state;
    logic [QCNT_W-1:0] qcnt;
    logic [1:0]        phase;
    logic [3:0]        bit_idx;
    logic [1:0]        byte_idx;
    logic [1:0]        last_idx;
    logic              rd_mode;
    logic [23:0]       wbuf;
    logic [7:0]        shreg;
    logic [2:0]        sda_sync;
    logic              sda_q;
    logic              tick;
    logic              tx_byte;
    logic              last_byte;
    logic              ack_bad;

    assign tick      = (qcnt == QCNT_W'(QTR_CYC - 1));
    assign tx_byte   = (byte_idx == 2'h0) || !rd_mode;
    assign last_byte = (byte_idx == last_idx);

    // Data line sync; change taken once stages two and three agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sda_sync <= SYNC_IDLE;
            sda_q    <= 1'b1;
        end else if (clk_en) begin
            sda_sync <= {sda_sync[1:0], bus.sda};
            if (sda_sync[1] == sda_sync[2]) begin
                sda_q <= sda_sync[2];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            qcnt <= '0;
        end else if (clk_en) begin
            if (state == CMP_H_IDLE || tick) begin
                qcnt <= '0;
            end else begin
                qcnt <= qcnt + 1'b1;
            end
        end
    end

    // Open-drain: drive value held low, enable pulls the line
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus.scl_host_o <= 1'b0;
            bus.sda_host_o <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state           <= CMP_H_IDLE;
            phase           <= '0;
            bit_idx         <= '0;
            byte_idx        <= '0;
            last_idx        <= '0;
            rd_mode         <= 1'b0;
            wbuf            <= '0;
            shreg           <= '0;
            ack_bad         <= 1'b0;
            cmd_ready       <= 1'b1;
            done            <= 1'b0;
            nack            <= 1'b0;
            rd_data         <= '0;
            bus.scl_host_oe <= 1'b0;
            bus.sda_host_oe <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (state)
                CMP_H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        nack      <= 1'b0;
                        rd_mode   <= cmd_read;
                        last_idx  <= cmd_len;
                        wbuf      <= cmd_wdata;
                        shreg     <= cmd_read ? ADDR_RD_BYTE : ADDR_WR_BYTE;
                        byte_idx  <= '0;
                        phase     <= '0;
                        state     <= CMP_H_START;
                    end
                end
                CMP_H_START: begin
                    if (tick) begin
                        phase <= phase + 1'b1;
                        if (phase == 2'h1) begin
                            bus.sda_host_oe <= 1'b1;
                        end
                        if (phase == 2'h3) begin
                            bus.scl_host_oe <= 1'b1;
                            bit_idx         <= '0;
                            state           <= CMP_H_BIT;
                        end
                    end
                end
                CMP_H_BIT: begin
                    if (tick) begin
                        phase <= phase + 1'b1;
                        case (phase)
                            2'h0: begin
                                if (bit_idx != 4'(BYTE_W)) begin
                                    bus.sda_host_oe <= tx_byte && !shreg[7];
                                end else begin
                                    bus.sda_host_oe <= !tx_byte && !last_byte;
                                end
                            end
                            2'h1: begin
                                bus.scl_host_oe <= 1'b0;
                            end
                            2'h2: begin
                                if (bit_idx == 4'(BYTE_W)) begin
                                    ack_bad <= (sda_q != ACK_LEVEL);
                                end else if (!tx_byte) begin
                                    shreg <= {shreg[6:0], sda_q};
                                end
                            end
                            default: begin
                                bus.scl_host_oe <= 1'b1;
                                if (bit_idx != 4'(XFER_BITS - 1)) begin
                                    bit_idx <= bit_idx + 1'b1;
                                    if (tx_byte) begin
                                        shreg <= {shreg[6:0], 1'b0};
                                    end
                                end else begin
                                    bit_idx <= '0;
                                    if (!tx_byte) begin
                                        rd_data <= {rd_data[7:0], shreg};
                                    end
                                    if (tx_byte && ack_bad) begin
                                        nack  <= 1'b1;
                                        state <= CMP_H_STOP;
                                    end else if (last_byte) begin
                                        state <= CMP_H_STOP;
                                    end else begin
                                        byte_idx <= byte_idx + 1'b1;
                                        case (byte_idx)
                                            2'h0:    shreg <= wbuf[23:16];
                                            2'h1:    shreg <= wbuf[15:8];
                                            default: shreg <= wbuf[7:0];
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                CMP_H_STOP: begin
                    if (tick) begin
                        phase <= phase + 1'b1;
                        case (phase)
                            2'h0:    bus.sda_host_oe <= 1'b1;
                            2'h1:    bus.scl_host_oe <= 1'b0;
                            2'h2:    bus.sda_host_oe <= 1'b0;
                            default: begin
                                done      <= 1'b1;
                                cmd_ready <= 1'b1;
                                state     <= CMP_H_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state <= CMP_H_IDLE;
                end
            endcase
        end
    end
endmodule : cmp_i2c_host

// >>> dv/cmp_i2c_chk.sv
`timescale 1ns/1ps
module cmp_i2c_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_host_o,
    input wire logic scl_host_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    import cmp_pkg::*;
    logic [9:0] per;
    logic [5:0] nr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Cycles since last clock rise, saturating
    always_ff @(posedge clock) begin
        if (sys_rst) per <= 10'h000;
        else if ($rose(scl)) per <= 10'h000;
        else if (per != 10'h3FF) per <= per + 10'h001;
    end
    // Clock rises since the last start
    always_ff @(posedge clock) begin
        if (sys_rst) nr <= 6'h00;
        else if ($fell(sda) && scl) nr <= 6'h00;
        else if ($rose(scl)) nr <= nr + 6'h01;
    end
    a_dev_pull_only: assert property (sda_dev_oe |-> !sda_dev_o)
        else $error("dev drives high");
    a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("dev moved sda");
    a_dev_bit_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
        else $error("dev short");
    a_bit_period: assert property ($rose(scl) |-> per >= 10'h18F)
        else $error("clock too fast");
    a_nine_clocks: assert property ($rose(sda) && scl |-> nr % XFER_BITS == 1)
        else $error("bits");
    a_start_by_host: assert property ($fell(sda) && scl
        |-> sda_host_oe && !sda_host_o) else $error("bad start");
    a_host_clocks: assert property ($fell(scl) |-> scl_host_oe && !scl_host_o)
        else $error("clk");
    a_addr_ack: assert property ($rose(scl) && nr == 6'h08
        |-> !sda_host_oe && sda_dev_oe) else $error("address ack wrong");
    a_addr_quiet: assert property ($rose(scl) && nr < 6'h08 |-> !sda_dev_oe)
        else $error("dev early");
endmodule : cmp_i2c_chk

// >>> dv/test_compass_i2c_slave_port.sv
`timescale 1ns/1ps
module test_compass_i2c_slave_port;
    import cmp_pkg::*;
    typedef struct packed {logic [16:0] v; logic [16:0] m;} cmp_exp_t;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_read = 1'b0;
    logic [1:0]  cmd_len = 2'h0;
    logic [23:0] cmd_wdata = 24'h000000;
    logic        rx_ready = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic        cmd_ready, done, nack, rx_valid, rx_first, tx_taken, selected;
    logic [15:0] rd_data;
    logic [7:0]  rx_data;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    cmp_exp_t    exp_q[$];
    cmp_exp_t    e;
    logic [8:0]  rx_q[$];
    logic [7:0]  tx_q[$];
    cmp_i2c_if bus_i ();
    cmp_i2c_host cmp_i2c_host_i (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_len(cmd_len),
        .cmd_wdata(cmd_wdata), .done(done), .nack(nack), .rd_data(rd_data));
    cmp_i2c_dev cmp_i2c_dev_i (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus_i),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first),
        .tx_data(tx_data), .tx_taken(tx_taken), .selected(selected));
    cmp_i2c_chk cmp_i2c_chk_i (.clock(clock), .sys_rst(sys_rst), .scl_host_o(bus_i.scl_host_o),
        .scl_host_oe(bus_i.scl_host_oe), .sda_host_o(bus_i.sda_host_o),
        .sda_host_oe(bus_i.sda_host_oe), .sda_dev_o(bus_i.sda_dev_o),
        .sda_dev_oe(bus_i.sda_dev_oe), .scl(bus_i.scl), .sda(bus_i.sda));
    always #12.5 clock = ~clock;
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // Notes expectations, then holds the request over its accepting edge
    task automatic run(input string name, input logic rd, input logic [1:0] len,
                       input logic [23:0] wd);
        logic [15:0] b;
        b = 16'($urandom);
        if (rd) begin
            tx_q.push_back(b[15:8]);
            if (len == 2'h2) tx_q.push_back(b[7:0]);
            exp_q.push_back(len == 2'h2 ? {1'b0, b, 17'h1FFFF} : {9'h000, b[15:8], 17'h100FF});
        end else begin
            for (int i = 0; i < len; i++) rx_q.push_back({i == 0, wd[23 - 8 * i -: 8]});
            exp_q.push_back({17'h00000, 17'h10000});
        end
        cmd_read = rd;
        cmd_len = len;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(negedge clock);
        @(negedge clock);
        $display("test %s done", name);
    endtask : run
    // Next read byte offered as soon as the last one was taken
    always @(negedge clock) begin
        if (tx_taken === 1'b1 && tx_q.size() > 0) tx_q.delete(0);
        tx_data = (tx_q.size() > 0) ? tx_q[0] : 8'($urandom);
    end
    // Results taken at the edge that consumes them; no race with the ready driver
    always @(posedge clock) begin
        if (done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("host result", {nack, rd_data} & e.m, e.v);
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1 && rx_q.size() > 0)
            check("rx byte", {8'h00, rx_first, rx_data}, {8'h00, rx_q.pop_front()});
        if (tx_taken === 1'b1)
            check("selected", {16'h0000, selected}, 17'h00001);
    end
    // Hang guard: runs need about 47200 cycles, some four fifths of this many
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(75446));
        repeat (10) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        run("write three", 1'b0, 2'h3, 24'($urandom));
        run("write one", 1'b0, 2'h1, {8'h41, 16'($urandom)});
        check("rx held", {16'h0000, rx_valid}, 17'h00001);
        rx_ready = 1'b1;
        run("address only", 1'b0, 2'h0, 24'h000000);
        run("read two", 1'b1, 2'h2, 24'h000000);
        run("read one", 1'b1, 2'h1, 24'h000000);
        check("rx empty", {16'h0000, rx_valid}, 17'h00000);
        end_sim();
    end
endmodule : test_compass_i2c_slave_port
